// >>> pkg/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// clock
`define SCS_CLK_NS 10
`define SCS_CLK_MHZ 100

// supervision times, each in its own unit
`define SCS_T_VINT_MS 1
`define SCS_T_REC_MS 45
`define SCS_T_EXT_US 2
`define SCS_T1_US 10
`define SCS_T2_US 100

// clock monitor
`define SCS_AUX_MHZ 14
`define SCS_TOL_PCT 25

// reset-cause flag positions
`define SCS_FLAG_VINT 0
`define SCS_FLAG_IO 1
`define SCS_FLAG_FIVE 2
`define SCS_FLAG_EXT 3
`define SCS_FLAG_CLK 4
`define SCS_NFLAGS 5

// reset values
`define SCS_FLAGS_RST 5'h01
`define SCS_AUX_EN_RST 1'h1

`endif

// >>> pkg/scs_pkg.sv
`include "scs_consts.svh"

package scs_pkg;

  typedef enum logic [1:0] {
    SCS_RUN,
    SCS_FAULT,
    SCS_RECOVER
  } scs_state_t;

  typedef enum int {
    SCS_CH_VINT,
    SCS_CH_IO,
    SCS_CH_FIVE,
    SCS_CH_BATT,
    SCS_CH_EXT,
    SCS_CH_N
  } scs_chan_t;

  // least time to cycles: round up, never below one
  function automatic int scs_ns2cyc(input int ns);
    int c;
    c = (ns + `SCS_CLK_NS - 1) / `SCS_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// >>> core/scs_clk_monitor.sv
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_clk_monitor
  import scs_pkg::*;
#(
  parameter int WIN_CYC = 10000,
  parameter int STOP_CYC = 1000,
  parameter int EXP_EDGES = 1400,
  parameter int TOL_PCT = `SCS_TOL_PCT
) (
  input wire logic clk_i,     // main oscillator domain clock
  input wire logic rst_n_i,   // sync reset, active low
  input wire logic enable_i,  // monitoring allowed
  input wire logic aux_osc_i, // aux oscillator level
  output logic fault_o        // one-cycle fault pulse
);

  localparam int LO = (EXP_EDGES * (100 - TOL_PCT)) / 100;
  localparam int HI = (EXP_EDGES * (100 + TOL_PCT)) / 100;

  logic aux_q_reg;
  logic [23:0] win_cnt_reg;
  logic [15:0] edge_cnt_reg;
  logic [23:0] idle_cnt_reg;
  logic fault_reg;

  wire aux_rise = aux_osc_i & ~aux_q_reg;
  wire win_end = (win_cnt_reg == 24'(WIN_CYC - 1));
  wire out_band = (edge_cnt_reg < 16'(LO)) || (edge_cnt_reg > 16'(HI));
  wire stopped = (idle_cnt_reg == 24'(STOP_CYC - 1));
  // window is timed on the main clock, so a drifting main clock skews it
  wire fault_next = enable_i & ((win_end & out_band) | stopped);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !enable_i) begin
      win_cnt_reg <= 24'h00_0000;
      edge_cnt_reg <= 16'h0000;
      idle_cnt_reg <= 24'h00_0000;
    end else begin
      win_cnt_reg <= win_end ? 24'h00_0000 : win_cnt_reg + 24'h00_0001;
      if (win_end) begin
        edge_cnt_reg <= 16'(aux_rise);
      end else begin
        edge_cnt_reg <= edge_cnt_reg + 16'(aux_rise);
      end
      idle_cnt_reg <= (aux_rise || stopped) ? 24'h00_0000 : idle_cnt_reg + 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aux_q_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      aux_q_reg <= aux_osc_i;
      fault_reg <= fault_next;
    end
  end

  assign fault_o = fault_reg;

endmodule

// >>> core/scs_supervisor.sv
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_supervisor
  import scs_pkg::*;
#(
  parameter int VINT_CYC = scs_ns2cyc(`SCS_T_VINT_MS * 1000000),
  parameter int REC_CYC = scs_ns2cyc(`SCS_T_REC_MS * 1000000),
  parameter int T2_CYC = scs_ns2cyc(`SCS_T2_US * 1000),
  parameter int ADC_W = 10
) (
  input wire logic clk_i,                        // 100 MHz system clock
  input wire logic rst_n_i,                      // sync reset, active low
  input wire logic vint_a_uv_i,                  // internal analog supply low
  input wire logic vint_d_uv_i,                  // internal digital supply low
  input wire logic io_supply_uv_i,               // io supply low
  input wire logic five_volt_supply_uv_i,        // five volt supply low
  input wire logic battery_supply_ov_i,          // battery over voltage
  input wire logic battery_supply_uv_i,          // battery under voltage
  input wire logic system_reset_line_n_i,        // reset line level
  output logic system_reset_line_n_o,            // reset line drive value
  output logic system_reset_line_n_oe_o,         // high while pulling low
  input wire logic aux_oscillator_i,             // aux oscillator level
  input wire logic spi_msg0_write_i,             // write of message zero
  input wire logic spi_flags_read_i,             // read returning cause flags
  input wire logic spi_ctrl_write_i,             // loads spread bits
  input wire logic spread_spectrum_enable_i,     // spread enable write data
  input wire logic spread_deviation_select_i,    // deviation write data
  input wire logic aux_oscillator_stop_cmd_i,    // stop aux oscillator
  input wire logic aux_oscillator_start_cmd_i,   // restart aux oscillator
  input wire logic temp_warning_i,               // live warning comparator
  input wire logic [ADC_W-1:0] gate_regulator_a_i, // regulator a sample
  input wire logic [ADC_W-1:0] gate_regulator_b_i, // regulator b sample
  output logic low_side_outputs_off_o,           // force low sides off
  output logic pump_predriver_state_on_o,        // force pump pre-driver on
  output logic pump_predriver_state_off_o,       // force pump pre-driver off
  output logic load_driver_output_off_o,         // force load driver off
  output logic spi_regs_init_o,                  // all registers to init
  output logic low_side_regs_init_o,             // low-side set points to init
  output logic internal_supply_low_flag_o,       // cause flag
  output logic io_supply_low_flag_o,             // cause flag
  output logic five_volt_low_flag_o,             // cause flag
  output logic ext_reset_flag_o,                 // cause flag
  output logic clock_fault_flag_o,               // cause flag
  output logic aux_oscillator_enable_o,          // aux oscillator runs
  output logic clock_monitor_active_o,           // monitor running
  output logic spread_spectrum_enable_o,         // modulation on
  output logic spread_deviation_select_o,        // 0: 350 kHz, 1: 700 kHz
  output logic temp_warning_o,                   // live warning bit
  output logic [ADC_W-1:0] gate_regulator_a_o,   // message 6 data
  output logic [ADC_W-1:0] gate_regulator_b_o    // message 7 data
);

  localparam int NCH = int'(SCS_CH_N);
  localparam int CW = 23;
  localparam int NF = `SCS_NFLAGS;
  localparam int T1_CYC = scs_ns2cyc(`SCS_T1_US * 1000);
  localparam int EXT_CYC = scs_ns2cyc(`SCS_T_EXT_US * 1000);
  localparam int EXP_EDGES = (T2_CYC / `SCS_CLK_MHZ) * `SCS_AUX_MHZ;

  scs_state_t state_reg;
  scs_state_t state_next;
  logic [CW-1:0] rec_cnt_reg;
  logic [CW-1:0] rec_cnt_next;
  logic [CW-1:0] flt_cnt_reg [NCH];
  logic [CW-1:0] flt_cnt_next [NCH];
  logic [CW-1:0] flt_lim [NCH];
  logic [NCH-1:0] flt_state_reg;
  logic [NCH-1:0] flt_state_next;
  logic [NCH-1:0] flt_raw;
  logic [NF-1:0] flags_reg;
  logic [NF-1:0] flags_next;
  logic [NF-1:0] flag_set;
  logic [NF-1:0] flag_wipe;
  logic ext_cause_reg;
  logic ext_cause_next;
  logic aux_en_reg;
  logic spread_spectrum_enable_reg;
  logic fm_dev_reg;
  logic temp_reg;
  logic [ADC_W-1:0] gate_a_reg;
  logic [ADC_W-1:0] gate_b_reg;
  logic clk_evt;
  logic drive_low;

  // comparator filters: per channel assert and release times
  wire [NCH-1:0] evt = flt_state_next & ~flt_state_reg;
  wire vint_f = flt_state_reg[SCS_CH_VINT];
  wire io_f = flt_state_reg[SCS_CH_IO];
  wire five_f = flt_state_reg[SCS_CH_FIVE];
  wire batt_f = flt_state_reg[SCS_CH_BATT];
  wire ext_f = flt_state_reg[SCS_CH_EXT];
  wire dev_fault = vint_f | io_f | five_f;
  wire any_fault = dev_fault | ext_f;
  wire in_reset = (state_reg != SCS_RUN);

  assign flt_raw[SCS_CH_VINT] = vint_a_uv_i | vint_d_uv_i;
  assign flt_raw[SCS_CH_IO] = io_supply_uv_i;
  assign flt_raw[SCS_CH_FIVE] = five_volt_supply_uv_i;
  assign flt_raw[SCS_CH_BATT] = battery_supply_ov_i | battery_supply_uv_i;
  // own pull-down is not an external reset
  assign flt_raw[SCS_CH_EXT] = ~system_reset_line_n_i & ~drive_low;
  // same time both ways, except the external input whose release is immediate
  assign flt_lim[SCS_CH_VINT] = CW'(VINT_CYC - 1);
  assign flt_lim[SCS_CH_IO] = CW'(T1_CYC - 1);
  assign flt_lim[SCS_CH_FIVE] = CW'(T1_CYC - 1);
  assign flt_lim[SCS_CH_BATT] = CW'(T2_CYC - 1);
  assign flt_lim[SCS_CH_EXT] = flt_raw[SCS_CH_EXT] ? CW'(EXT_CYC - 1) : '0;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      flt_cnt_next[i] = '0;
      flt_state_next[i] = flt_state_reg[i];
      if (flt_raw[i] != flt_state_reg[i]) begin
        if (flt_cnt_reg[i] >= flt_lim[i]) begin
          flt_state_next[i] = flt_raw[i];
        end else begin
          flt_cnt_next[i] = flt_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flt_state_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        flt_cnt_reg[i] <= '0;
      end
    end else begin
      flt_state_reg <= flt_state_next;
      flt_cnt_reg <= flt_cnt_next;
    end
  end

  // reset sequencer
  always_comb begin
    state_next = state_reg;
    rec_cnt_next = rec_cnt_reg;
    case (state_reg)
      SCS_RUN: begin
        if (any_fault || clk_evt) begin
          state_next = SCS_FAULT;
        end
      end
      SCS_FAULT: begin
        if (!any_fault) begin
          state_next = SCS_RECOVER;
          rec_cnt_next = '0;
        end
      end
      SCS_RECOVER: begin
        if (any_fault) begin
          state_next = SCS_FAULT;
        end else if (rec_cnt_reg == CW'(REC_CYC - 1)) begin
          state_next = SCS_RUN;
        end else begin
          rec_cnt_next = rec_cnt_reg + 1'b1;
        end
      end
      default: begin
        state_next = SCS_FAULT;
      end
    endcase
  end

  // external-only resets leave the line to the host
  assign ext_cause_next = (state_reg == SCS_RUN) ? (ext_f & ~dev_fault & ~clk_evt)
                                                 : (ext_cause_reg & ~dev_fault);
  assign drive_low = in_reset & ~ext_cause_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= SCS_RECOVER;
      rec_cnt_reg <= '0;
      ext_cause_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rec_cnt_reg <= rec_cnt_next;
      ext_cause_reg <= ext_cause_next;
    end
  end

  // reset-cause flags; a new cause beats a clear in the same cycle
  assign flag_set[`SCS_FLAG_VINT] = evt[SCS_CH_VINT];
  assign flag_set[`SCS_FLAG_IO] = evt[SCS_CH_IO];
  assign flag_set[`SCS_FLAG_FIVE] = evt[SCS_CH_FIVE];
  assign flag_set[`SCS_FLAG_EXT] = evt[SCS_CH_EXT];
  assign flag_set[`SCS_FLAG_CLK] = clk_evt;
  // internal supply loss wipes the others; clock fail keeps the internal flag
  assign flag_wipe[`SCS_FLAG_VINT] = 1'b0;
  assign flag_wipe[`SCS_FLAG_IO] = evt[SCS_CH_VINT] | clk_evt;
  assign flag_wipe[`SCS_FLAG_FIVE] = evt[SCS_CH_VINT] | clk_evt;
  assign flag_wipe[`SCS_FLAG_EXT] = evt[SCS_CH_VINT] | clk_evt;
  assign flag_wipe[`SCS_FLAG_CLK] = evt[SCS_CH_VINT];
  wire clr_all = spi_msg0_write_i | spi_flags_read_i;
  assign flags_next = flag_set | (flags_reg & ~flag_wipe & ~{NF{clr_all}});
  // control bits written over spi
  wire aux_en_next = (aux_en_reg | aux_oscillator_start_cmd_i)
                     & ~aux_oscillator_stop_cmd_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_reg <= `SCS_FLAGS_RST;
      aux_en_reg <= `SCS_AUX_EN_RST;
      spread_spectrum_enable_reg <= 1'b0;
      fm_dev_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      if (in_reset) begin
        aux_en_reg <= `SCS_AUX_EN_RST;
        spread_spectrum_enable_reg <= 1'b0;
        fm_dev_reg <= 1'b0;
      end else begin
        aux_en_reg <= aux_en_next;
        if (spi_ctrl_write_i) begin
          spread_spectrum_enable_reg <= spread_spectrum_enable_i;
          fm_dev_reg <= spread_deviation_select_i;
        end
      end
    end
  end

  // status samples; the warning never gates an output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      temp_reg <= 1'b0;
      gate_a_reg <= '0;
      gate_b_reg <= '0;
    end else begin
      temp_reg <= temp_warning_i;
      gate_a_reg <= gate_regulator_a_i;
      gate_b_reg <= gate_regulator_b_i;
    end
  end

  // monitor only with the line released and the old clock flag read out;
  // an aux restart can settle slowly and trip it, which the flag reports
  wire mon_en = ~in_reset & system_reset_line_n_i & aux_en_reg
                & ~flags_reg[`SCS_FLAG_CLK];

  scs_clk_monitor #(
    .WIN_CYC(T2_CYC),
    .STOP_CYC(T1_CYC),
    .EXP_EDGES(EXP_EDGES),
    .TOL_PCT(`SCS_TOL_PCT)
  ) u_mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(mon_en),
    .aux_osc_i(aux_oscillator_i),
    .fault_o(clk_evt)
  );

  // output forcing
  assign system_reset_line_n_o = 1'b0;
  assign system_reset_line_n_oe_o = drive_low;
  assign low_side_outputs_off_o = in_reset | batt_f;
  assign pump_predriver_state_on_o = batt_f & ~in_reset;
  assign pump_predriver_state_off_o = in_reset;
  assign load_driver_output_off_o = in_reset;
  assign spi_regs_init_o = in_reset;
  assign low_side_regs_init_o = in_reset | batt_f;
  assign internal_supply_low_flag_o = flags_reg[`SCS_FLAG_VINT];
  assign io_supply_low_flag_o = flags_reg[`SCS_FLAG_IO];
  assign five_volt_low_flag_o = flags_reg[`SCS_FLAG_FIVE];
  assign ext_reset_flag_o = flags_reg[`SCS_FLAG_EXT];
  assign clock_fault_flag_o = flags_reg[`SCS_FLAG_CLK];
  assign aux_oscillator_enable_o = aux_en_reg;
  assign clock_monitor_active_o = mon_en;
  assign spread_spectrum_enable_o = spread_spectrum_enable_reg;
  assign spread_deviation_select_o = fm_dev_reg;
  assign temp_warning_o = temp_reg;
  assign gate_regulator_a_o = gate_a_reg;
  assign gate_regulator_b_o = gate_b_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_vint_loss; $rose(vint_f); endsequence
  property p_vint_reset;
    s_vint_loss |-> internal_supply_low_flag_o && !io_supply_low_flag_o
                    && !clock_fault_flag_o ##1 system_reset_line_n_oe_o;
  endproperty
  a_vint_reset: assert property (p_vint_reset)
    else $error("internal supply loss not handled");
  property p_clk_fail;
    clk_evt && !any_fault |=> clock_fault_flag_o && system_reset_line_n_oe_o
                              && load_driver_output_off_o && !ext_reset_flag_o;
  endproperty
  a_clk_fail: assert property (p_clk_fail)
    else $error("clock fault did not reset");
  // no flag that was set may drop while the reset lasts unless cleared or wiped by an internal supply or clock event
  property p_flags_kept;
    in_reset && !clr_all && !evt[SCS_CH_VINT] && !clk_evt
      |=> ($past(flags_reg) & ~flags_reg) == '0;
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("cause flag lost during reset");
  property p_battery;
    batt_f && !in_reset |-> low_side_outputs_off_o && pump_predriver_state_on_o
                            && !load_driver_output_off_o && !system_reset_line_n_oe_o;
  endproperty
  a_battery: assert property (p_battery)
    else $error("battery fault reaction wrong");
  sequence s_recover_entry; state_reg == SCS_FAULT ##1 state_reg == SCS_RECOVER; endsequence
  property p_hold_recovery;
    s_recover_entry ##0 !any_fault[*8] |-> in_reset && rec_cnt_reg == CW'(7);
  endproperty
  a_hold_recovery: assert property (p_hold_recovery)
    else $error("recovery not timed");
  sequence s_clear_req; clr_all && flag_set == '0; endsequence
  property p_clear;
    s_clear_req |=> flags_reg == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flags not cleared");
  property p_monitor_gate;
    !clock_monitor_active_o |=> !clk_evt;
  endproperty
  a_monitor_gate: assert property (p_monitor_gate)
    else $error("monitor ran while gated");
  property p_aux_stop;
    aux_oscillator_stop_cmd_i && !in_reset |=> !aux_oscillator_enable_o
                                               && !clock_monitor_active_o;
  endproperty
  a_aux_stop: assert property (p_aux_stop)
    else $error("aux stop ignored");
  property p_ext_glitch;
    $fell(system_reset_line_n_i) && !drive_low ##1 system_reset_line_n_i |=> !ext_f;
  endproperty
  a_ext_glitch: assert property (p_ext_glitch)
    else $error("short reset glitch accepted");
  property p_fm_load;
    spi_ctrl_write_i && !in_reset |=> spread_spectrum_enable_o == $past(spread_spectrum_enable_i)
                                      && spread_deviation_select_o
                                         == $past(spread_deviation_select_i);
  endproperty
  a_fm_load: assert property (p_fm_load)
    else $error("spread bits not loaded");
  property p_temp_live;
    temp_warning_i |=> temp_warning_o ##0 !low_side_outputs_off_o || in_reset || batt_f;
  endproperty
  a_temp_live: assert property (p_temp_live)
    else $error("warning not live");
endmodule

// >>> bench/scs_host_model.sv
`timescale 1ns/1ps

module scs_host_model (
  input wire logic clk_i,       // system clock
  input wire logic dev_oe_i,    // device pulls reset line low
  input wire logic pull_req_i,  // bench asks for an external reset
  input wire logic msg0_req_i,  // bench asks for a message zero write
  output logic line_n_o,        // resolved reset wire
  output logic msg0_write_o     // one-cycle message zero write
);
  logic msg0_req_reg = 1'h0;
  // open drain with pull-up: low while either party pulls
  assign line_n_o = ~(dev_oe_i | pull_req_i);
  always_ff @(posedge clk_i) begin
    msg0_req_reg <= msg0_req_i;
  end
  // host talks only once released, and its first message is the flag-clearing write
  assign msg0_write_o = msg0_req_i & ~msg0_req_reg & line_n_o;
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import scs_pkg::*;
  localparam int VC = 20;
  localparam int RC = 50;
  localparam int T2 = 300;
  localparam int T1 = 1000;
  logic clk_i = 1'h0, rst_n_i = 1'h0, va = 1'h0, vd = 1'h0, io = 1'h0, fv = 1'h0;
  logic bov = 1'h0, buv = 1'h0, pull = 1'h0, m0 = 1'h0, rd = 1'h0, cw = 1'h0;
  logic fe = 1'h0, fs = 1'h0, stp = 1'h0, sta = 1'h0, tw = 1'h0, aux = 1'h0, aux_run = 1'h1;
  logic [9:0] ga = 10'h000, gb = 10'h000, ga_o, gb_o;
  logic line, line_o, oe, m0w, lo_off, pon, poff, ld_off, init, ls_init;
  logic f_vint, f_io, f_five, f_ext, f_clk, aux_en, mon, fe_o, fs_o, tw_o;
  int aux_half = 35;
  int mismatches = 0;
  int num_checks = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // offset keeps aux edges off the sampling edge
  initial begin
    #1;
    forever #aux_half aux = aux_run ? ~aux : aux;
  end
  scs_supervisor #(.VINT_CYC(VC), .REC_CYC(RC), .T2_CYC(T2), .ADC_W(10)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .vint_a_uv_i(va), .vint_d_uv_i(vd),
    .io_supply_uv_i(io), .five_volt_supply_uv_i(fv), .battery_supply_ov_i(bov),
    .battery_supply_uv_i(buv), .system_reset_line_n_i(line), .system_reset_line_n_o(line_o),
    .system_reset_line_n_oe_o(oe), .aux_oscillator_i(aux), .spi_msg0_write_i(m0w),
    .spi_flags_read_i(rd), .spi_ctrl_write_i(cw), .spread_spectrum_enable_i(fe),
    .spread_deviation_select_i(fs), .aux_oscillator_stop_cmd_i(stp),
    .aux_oscillator_start_cmd_i(sta), .temp_warning_i(tw), .gate_regulator_a_i(ga),
    .gate_regulator_b_i(gb), .low_side_outputs_off_o(lo_off),
    .pump_predriver_state_on_o(pon), .pump_predriver_state_off_o(poff),
    .load_driver_output_off_o(ld_off), .spi_regs_init_o(init), .low_side_regs_init_o(ls_init),
    .internal_supply_low_flag_o(f_vint), .io_supply_low_flag_o(f_io),
    .five_volt_low_flag_o(f_five), .ext_reset_flag_o(f_ext), .clock_fault_flag_o(f_clk),
    .aux_oscillator_enable_o(aux_en), .clock_monitor_active_o(mon),
    .spread_spectrum_enable_o(fe_o), .spread_deviation_select_o(fs_o),
    .temp_warning_o(tw_o), .gate_regulator_a_o(ga_o), .gate_regulator_b_o(gb_o));
  scs_host_model host (.clk_i(clk_i), .dev_oe_i(oe), .pull_req_i(pull), .msg0_req_i(m0),
    .line_n_o(line), .msg0_write_o(m0w));
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input string n, input logic [9:0] s, input logic [9:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task clear(input logic by_read);
    m0 = ~by_read;
    rd = by_read;
    cyc(1);
    m0 = 1'h0;
    rd = 1'h0;
    cyc(2);
    chk("flags", {f_vint, f_io, f_five, f_ext, f_clk}, 10'h000);
  endtask
  task t_power();
    chk("rst", {oe, f_vint, init, pon, aux_en, fe_o, fs_o}, 10'h074);
    chk("line_o", line_o, 1'h0);
    cyc(RC - 5);
    chk("oe", oe, 1'h1);
    cyc(10);
    chk("run", {line, mon}, 10'h003);
    clear(1'h0);
  endtask
  task t_live();
    tw = 1'h1;
    ga = 10'h0155;
    gb = 10'h02aa;
    cyc(2);
    chk("tw", {tw_o, lo_off, ld_off}, 10'h004);
    chk("ga", ga_o, 10'h0155);
    chk("gb", gb_o, 10'h02aa);
    tw = 1'h0;
  endtask
  task t_ctrl();
    for (int k = 0; k < 4; k++) begin
      fe = k[0];
      fs = k[1];
      cw = 1'h1;
      cyc(1);
      cw = 1'h0;
      cyc(1);
      chk("fm", {fe_o, fs_o}, {k[0], k[1]});
    end
  endtask
  task t_vint();
    vd = 1'h1;
    cyc(VC - 2);
    chk("oe", oe, 1'h0);
    cyc(5);
    chk("vint", {oe, lo_off, poff, ld_off, init, f_vint, mon}, 10'h07e);
    cyc(100);
    va = 1'h1;
    vd = 1'h0;
    cyc(100);
    va = 1'h0;
    cyc(VC + RC - 5);
    chk("oe", oe, 1'h1);
    cyc(15);
    chk("rel", {oe, f_vint}, 10'h001);
    clear(1'h0);
  endtask
  task t_supply();
    io = 1'h1;
    cyc(T1 + 3);
    chk("io", {oe, f_io, init}, 10'h007);
    fv = 1'h1;
    cyc(T1 + 3);
    chk("five", {f_io, f_five}, 10'h003);
    io = 1'h0;
    cyc(T1 + RC + 20);
    chk("oe", oe, 1'h1);
    fv = 1'h0;
    cyc(T1 + RC - 5);
    chk("oe", oe, 1'h1);
    cyc(15);
    chk("kept", {oe, f_io, f_five}, 10'h003);
    clear(1'h1);
  endtask
  task t_batt();
    for (int k = 0; k < 2; k++) begin
      bov = (k == 0);
      buv = (k == 1);
      cyc(T2 + 3);
      chk("bat", {lo_off, pon, ls_init, oe, ld_off, line}, 10'h039);
      bov = 1'h0;
      buv = 1'h0;
      cyc(T2 + 3);
      chk("bat", {lo_off, pon}, 10'h000);
    end
  endtask
  task t_ext();
    // single-cycle low pulse on the wire, then a 100-cycle one and a 250-cycle one
    pull = 1'h1;
    cyc(1);
    pull = 1'h0;
    cyc(2);
    chk("pulse", {f_ext, ld_off}, 10'h000);
    pull = 1'h1;
    cyc(100);
    pull = 1'h0;
    cyc(5);
    chk("glitch", {f_ext, ld_off}, 10'h000);
    pull = 1'h1;
    cyc(250);
    chk("ext", {f_ext, ld_off, init, oe}, 10'h00e);
    pull = 1'h0;
    cyc(RC + 10);
    chk("ext", ld_off, 1'h0);
    clear(1'h0);
  endtask
  task t_clk();
    int n;
    for (int k = 0; k < 2; k++) begin
      chk("mon", mon, 1'h1);
      aux_run = (k == 1);
      aux_half = k ? 55 : 35;
      n = 0;
      while (oe !== 1'h1 && n < 2 * T2 + 10) begin
        cyc(1);
        n++;
      end
      chk("cflt", {oe, f_clk, f_vint, init, ld_off}, 10'h01b);
      aux_run = 1'h1;
      aux_half = 35;
      cyc(RC + 50);
      chk("hold", {oe, mon}, 10'h000);
      clear(1'h1);
      chk("rearm", mon, 1'h1);
    end
  endtask
  task t_aux();
    stp = 1'h1;
    cyc(1);
    stp = 1'h0;
    aux_run = 1'h0;
    cyc(2 * T2 + 20);
    chk("stop", {aux_en, mon, oe, ld_off}, 10'h000);
    sta = 1'h1;
    cyc(1);
    sta = 1'h0;
    aux_run = 1'h1;
    cyc(2);
    chk("start", {aux_en, mon}, 10'h003);
  endtask
  task conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_n_i = 1'h1;
    t_power();
    t_live();
    t_ctrl();
    t_vint();
    t_supply();
    t_batt();
    t_ext();
    t_clk();
    t_aux();
    conclude();
  end
  // whole run is near 8k cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
